/* src/rtcr_regs.vh */
// Offsets, field layouts, reset values and mode codes of the register bank
`ifndef RTCR_REGS_VH
`define RTCR_REGS_VH

// ************************************************************
// Register byte offsets (host address lines A10..A1, A0 = 0)
// ************************************************************
`define RTCR_OFF_DMA_ADDR_HI   11'h020
`define RTCR_OFF_DMA_ADDR_LO   11'h022
`define RTCR_OFF_IMG_ADDR_HI   11'h042
`define RTCR_OFF_IMG_ADDR_LO   11'h044
`define RTCR_OFF_DMA_CNT_HI    11'h050
`define RTCR_OFF_DMA_CNT_LO    11'h054
`define RTCR_OFF_UCLIP_MAX_Y   11'h08E
`define RTCR_OFF_SCLIP_MAX_X   11'h090
`define RTCR_OFF_SCLIP_MAX_Y   11'h092
`define RTCR_OFF_RET_ADDR_HI   11'h094
`define RTCR_OFF_RET_ADDR_LO   11'h096
`define RTCR_OFF_COLOUR_OFS    11'h09A

// ************************************************************
// Field widths
// ************************************************************
`define RTCR_CLIP_W      14
`define RTCR_ADDR_HI_W   7
`define RTCR_ADDR_LO_W   15
`define RTCR_CNT_HI_W    3
`define RTCR_CNT_LO_W    16

// ************************************************************
// Reset values and mode encodings
// ************************************************************
`define RTCR_XFER_RST    16'h0000
`define RTCR_XM_DMA      2'h1
`define RTCR_XM_CONV     2'h3
`define RTCR_CM_A        3'h1
`define RTCR_CM_B        3'h2
`define RTCR_CM_C        3'h3
`define RTCR_CM_D        3'h7

`endif

/* src/rtcr_pinsync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rtcr_pinsync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire sys_clk_in,      // System clock
   input wire rst_in,          // Async reset, active high
   input wire [W-1:0] pin_in,  // Asynchronous pin levels
   output reg [W-1:0] level_out // Filtered level
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   reg [W-1:0] stage3;
   integer i;

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
         level_out <= INIT;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         // A bit changes only once two later stages agree
         for (i = 0; i < W; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule

/* src/rtcr_colsat.v */
// Saturating add of one signed colour offset to one colour component
`timescale 1ns/10ps
module rtcr_colsat #(
   parameter W = 5
) (
   input wire [W-1:0] comp_in,  // Unsigned source component
   input wire [W-1:0] ofs_in,   // Signed offset, sign in top bit
   output reg [W-1:0] sum_out   // Saturated result
);
   reg [W+1:0] sum;

   always @* begin
      sum = {2'b00, comp_in} + {{2{ofs_in[W-1]}}, ofs_in};
      if (sum[W+1]) begin
         sum_out = {W{1'b0}};
      end else if (sum[W]) begin
         sum_out = {W{1'b1}};
      end else begin
         sum_out = sum[W-1:0];
      end
   end
endmodule

/* src/rtcr_top.v */
// Rendering tail and data transfer control register bank with host port
`timescale 1ns/10ps
`include "rtcr_regs.vh"
module rtcr_top (
   input wire sys_clk_in,             // 40 MHz system clock
   input wire rst_in,                 // Async reset, active high
   input wire host_cs_n_in,           // Host chip select, active low
   input wire host_rd_n_in,           // Host read strobe, active low
   input wire host_wr_n_in,           // Host write strobe, active low
   input wire [10:1] host_addr_in,    // Host address A10..A1
   input wire [15:0] host_data_in,    // Host data bus, input side
   output reg [15:0] host_data_out,   // Host data bus, output side
   output reg host_data_oe_out,       // Drive enable of host data bus
   input wire [1:0] xfer_mode_in,     // Transfer mode field
   input wire [2:0] conv_mode_in,     // Conversion mode field
   input wire uclip_load_in,          // Engine loads user clip max Y
   input wire [13:0] uclip_max_y_in,  // User clip max Y from engine
   input wire sclip_load_in,          // Engine loads system clip maxima
   input wire [13:0] sclip_max_x_in,  // System clip max X from engine
   input wire [13:0] sclip_max_y_in,  // System clip max Y from engine
   input wire ret_load_in,            // Engine loads return address
   input wire [21:0] ret_addr_in,     // Return word address from engine
   input wire pix_valid_in,           // Source pixel valid
   input wire [15:0] pix_in,          // Source pixel, 5:6:5
   input wire bpp16_in,               // Drawing in 16 bits per pixel
   input wire quad_cmd_in,            // Textured quad command active
   input wire colour_offset_attribute_in, // Colour offset attribute
   output reg pix_valid_out,          // Result pixel valid
   output reg [15:0] pix_out,         // Result pixel, 5:6:5
   output reg [21:0] dma_dest_addr_out,   // DMA destination word address
   output reg [18:0] dma_word_count_out,  // DMA word count
   output reg dma_addr_use_out,       // DMA address and count in use
   output reg [21:0] image_dest_addr_out, // Image destination address
   output reg image_addr_use_out,     // Image address in use
   output reg [21:0] ret_addr_out     // Return word address to engine
);

   // ************************************************************
   // Host bus state machine encoding
   // ************************************************************
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_WR = 3'h2;
   localparam [2:0] ST_RD = 3'h4;

   // ************************************************************
   // Storage
   // ************************************************************
   reg [6:0] dma_dest_addr_high;
   reg [14:0] dma_dest_addr_low;
   reg [6:0] image_dest_addr_high;
   reg [14:0] image_dest_addr_low;
   reg [2:0] dma_word_count_high;
   reg [15:0] dma_word_count_low;
   reg [13:0] user_clip_max_y;
   reg [13:0] system_clip_max_x;
   reg [13:0] system_clip_max_y;
   reg [6:0] return_addr_high;
   reg [14:0] return_addr_low;
   reg [15:0] colour_offset;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [15:0] rd_mux;
   wire [2:0] strobes;
   wire cs_act;
   wire rd_act;
   wire wr_act;
   wire [10:0] addr;
   wire wr_take;
   wire [4:0] sat_red;
   wire [5:0] sat_green;
   wire [4:0] sat_blue;
   wire [3:0] xfer_sel;

   // ************************************************************
   // Helper functions
   // ************************************************************
   function conv_active;
      input [2:0] mode;
      begin
         conv_active = (mode == `RTCR_CM_A) || (mode == `RTCR_CM_B) ||
            (mode == `RTCR_CM_C) || (mode == `RTCR_CM_D);
      end
   endfunction

   // Word address pair as seen on reads: high in 6..0, low in 15..1
   function [15:0] hi_word;
      input [6:0] f;
      begin
         hi_word = {9'h000, f};
      end
   endfunction

   function [15:0] lo_word;
      input [14:0] f;
      begin
         lo_word = {f, 1'b0};
      end
   endfunction

   function [15:0] clip_word;
      input [13:0] f;
      begin
         clip_word = {2'b00, f};
      end
   endfunction

   // ************************************************************
   // Host pin synchronisation
   // ************************************************************
   rtcr_pinsync #(
      .W(3),
      .INIT(3'h7)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pin_in({host_cs_n_in, host_rd_n_in, host_wr_n_in}),
      .level_out(strobes)
   );

   assign cs_act = ~strobes[2];
   assign rd_act = cs_act & ~strobes[1];
   assign wr_act = cs_act & ~strobes[0];
   // Address and data are held steady by the host while a strobe is low
   assign addr = {host_addr_in, 1'b0};
   assign wr_take = (state == ST_IDLE) & wr_act;

   // One-hot select of transfer address register written this cycle
   assign xfer_sel[0] = wr_take & (addr == `RTCR_OFF_DMA_ADDR_HI);
   assign xfer_sel[1] = wr_take & (addr == `RTCR_OFF_DMA_ADDR_LO);
   assign xfer_sel[2] = wr_take & (addr == `RTCR_OFF_IMG_ADDR_HI);
   assign xfer_sel[3] = wr_take & (addr == `RTCR_OFF_IMG_ADDR_LO);

   // ************************************************************
   // Host bus sequencing
   // ************************************************************
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_act) begin
               next_state = ST_WR;
            end else if (rd_act) begin
               next_state = ST_RD;
            end
         end
         ST_WR: begin
            if (!wr_act) begin
               next_state = ST_IDLE;
            end
         end
         ST_RD: begin
            if (!rd_act) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Read multiplexer
   // ************************************************************
   // Unused bits read as zero everywhere, also where they may be undefined
   always @* begin
      case (addr)
         `RTCR_OFF_DMA_ADDR_HI: rd_mux = hi_word(dma_dest_addr_high);
         `RTCR_OFF_DMA_ADDR_LO: rd_mux = lo_word(dma_dest_addr_low);
         `RTCR_OFF_IMG_ADDR_HI: rd_mux = hi_word(image_dest_addr_high);
         `RTCR_OFF_IMG_ADDR_LO: rd_mux = lo_word(image_dest_addr_low);
         `RTCR_OFF_DMA_CNT_HI: rd_mux = {13'h0000, dma_word_count_high};
         `RTCR_OFF_DMA_CNT_LO: rd_mux = dma_word_count_low;
         `RTCR_OFF_UCLIP_MAX_Y: rd_mux = clip_word(user_clip_max_y);
         `RTCR_OFF_SCLIP_MAX_X: rd_mux = clip_word(system_clip_max_x);
         `RTCR_OFF_SCLIP_MAX_Y: rd_mux = clip_word(system_clip_max_y);
         `RTCR_OFF_RET_ADDR_HI: rd_mux = hi_word(return_addr_high);
         `RTCR_OFF_RET_ADDR_LO: rd_mux = lo_word(return_addr_low);
         `RTCR_OFF_COLOUR_OFS: rd_mux = colour_offset;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Data is refreshed every cycle of a read so the host sees live state
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         host_data_out <= 16'h0000;
         host_data_oe_out <= 1'b0;
      end else begin
         host_data_oe_out <= (next_state == ST_RD);
         if (next_state == ST_RD) begin
            host_data_out <= rd_mux;
         end
      end
   end

   // ************************************************************
   // Transfer control registers, cleared by reset
   // ************************************************************
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dma_dest_addr_high <= {`RTCR_ADDR_HI_W{1'b0}};
         dma_dest_addr_low <= {`RTCR_ADDR_LO_W{1'b0}};
         image_dest_addr_high <= {`RTCR_ADDR_HI_W{1'b0}};
         image_dest_addr_low <= {`RTCR_ADDR_LO_W{1'b0}};
         dma_word_count_high <= {`RTCR_CNT_HI_W{1'b0}};
         dma_word_count_low <= `RTCR_XFER_RST;
      end else begin
         // Only the host changes these; no stepping during transfers
         if (xfer_sel[0]) begin
            dma_dest_addr_high <= host_data_in[6:0];
         end
         if (xfer_sel[1]) begin
            dma_dest_addr_low <= host_data_in[15:1];
         end
         if (xfer_sel[2]) begin
            image_dest_addr_high <= host_data_in[6:0];
         end
         if (xfer_sel[3]) begin
            image_dest_addr_low <= host_data_in[15:1];
         end
         if (wr_take && addr == `RTCR_OFF_DMA_CNT_HI) begin
            dma_word_count_high <= host_data_in[2:0];
         end
         if (wr_take && addr == `RTCR_OFF_DMA_CNT_LO) begin
            dma_word_count_low <= host_data_in;
         end
      end
   end

   // ************************************************************
   // Rendering registers, kept across reset
   // ************************************************************
   // No reset term: contents must survive a reset of the renderer
   always @(posedge sys_clk_in) begin
      if (uclip_load_in) begin
         user_clip_max_y <= uclip_max_y_in;
      end
      // Host writes to the clip maxima are not decoded at all
      if (sclip_load_in) begin
         system_clip_max_x <= sclip_max_x_in;
         system_clip_max_y <= sclip_max_y_in;
      end
      // Engine load wins over a host write in the same cycle
      if (ret_load_in) begin
         return_addr_high <= ret_addr_in[21:15];
         return_addr_low <= ret_addr_in[14:0];
      end else if (wr_take && addr == `RTCR_OFF_RET_ADDR_HI) begin
         return_addr_high <= host_data_in[6:0];
      end
      if (wr_take && addr == `RTCR_OFF_COLOUR_OFS) begin
         colour_offset <= host_data_in;
      end
   end

   // ************************************************************
   // Colour offset path
   // ************************************************************
   rtcr_colsat #(
      .W(5)
   ) u_sat_red (
      .comp_in(pix_in[15:11]),
      .ofs_in(colour_offset[15:11]),
      .sum_out(sat_red)
   );

   rtcr_colsat #(
      .W(6)
   ) u_sat_green (
      .comp_in(pix_in[10:5]),
      .ofs_in(colour_offset[10:5]),
      .sum_out(sat_green)
   );

   rtcr_colsat #(
      .W(5)
   ) u_sat_blue (
      .comp_in(pix_in[4:0]),
      .ofs_in(colour_offset[4:0]),
      .sum_out(sat_blue)
   );

   // In 8-bit drawing the host keeps the attribute clear; bpp16 gates anyway
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pix_valid_out <= 1'b0;
         pix_out <= 16'h0000;
      end else begin
         pix_valid_out <= pix_valid_in;
         if (pix_valid_in) begin
            if (bpp16_in && quad_cmd_in && colour_offset_attribute_in) begin
               pix_out <= {sat_red, sat_green, sat_blue};
            end else begin
               pix_out <= pix_in;
            end
         end
      end
   end

   // ************************************************************
   // Addresses and counts to the transfer engines
   // ************************************************************
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dma_dest_addr_out <= 22'h000000;
         dma_word_count_out <= 19'h00000;
         dma_addr_use_out <= 1'b0;
         image_dest_addr_out <= 22'h000000;
         image_addr_use_out <= 1'b0;
      end else begin
         dma_dest_addr_out <= {dma_dest_addr_high, dma_dest_addr_low};
         dma_word_count_out <= {dma_word_count_high,
            dma_word_count_low};
         image_dest_addr_out <= {image_dest_addr_high,
            image_dest_addr_low};
         // Mode 11 routes data via the entry port to the image address
         dma_addr_use_out <= (xfer_mode_in == `RTCR_XM_DMA);
         image_addr_use_out <= (xfer_mode_in == `RTCR_XM_CONV) ||
            conv_active(conv_mode_in);
      end
   end

   // Return address is not cleared, so it follows storage without reset
   always @(posedge sys_clk_in) begin
      ret_addr_out <= {return_addr_high, return_addr_low};
   end

endmodule

/* test/rtcr_top_properties.sv */
// Port-level checks of the transfer control register bank
`timescale 1ns/10ps
module rtcr_props (
   input wire sys_clk_in, // System clock
   input wire rst_in, // Async reset
   input wire host_cs_n_in, // Chip select
   input wire host_rd_n_in, // Read strobe
   input wire host_wr_n_in, // Write strobe
   input wire host_data_oe_out, // Bus drive enable
   input wire [1:0] xfer_mode_in, // Transfer mode
   input wire [2:0] conv_mode_in, // Conversion mode
   input wire pix_valid_in, // Pixel valid in
   input wire [15:0] pix_in, // Pixel in
   input wire bpp16_in, // 16 bits per pixel
   input wire quad_cmd_in, // Quad command
   input wire colour_offset_attribute_in, // Offset attribute
   input wire pix_valid_out, // Pixel valid out
   input wire [15:0] pix_out, // Pixel out
   input wire [21:0] dma_dest_addr_out, // DMA address
   input wire [18:0] dma_word_count_out, // DMA count
   input wire dma_addr_use_out, // DMA in use
   input wire [21:0] image_dest_addr_out, // Image address
   input wire image_addr_use_out // Image in use
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   wire ofs_on = bpp16_in && quad_cmd_in && colour_offset_attribute_in;
   wire conv_on = conv_mode_in inside {3'h1, 3'h2, 3'h3, 3'h7};
   a_oe_on_read: assert property ($rose(host_data_oe_out) |->
      !host_cs_n_in && !host_rd_n_in) else $error("Drive without read");
   a_oe_rd_gone: assert property (host_rd_n_in [*8] |->
      !host_data_oe_out) else $error("Drive after read ended");
   a_oe_cs_gone: assert property (host_cs_n_in [*8] |->
      !host_data_oe_out) else $error("Drive while deselected");
   a_pix_pass: assert property (pix_valid_in && !ofs_on |=>
      pix_valid_out && pix_out == $past(pix_in)) else $error("Pixel altered");
   a_dma_use: assert property (xfer_mode_in == 2'h1 ##1
      xfer_mode_in == 2'h1 |-> dma_addr_use_out) else $error("DMA unused");
   a_conv_xfer: assert property (xfer_mode_in == 2'h3 ##1
      xfer_mode_in == 2'h3 |-> image_addr_use_out && !dma_addr_use_out)
      else $error("Mode 11 address choice");
   a_conv_use: assert property (conv_on ##1 conv_on |->
      image_addr_use_out) else $error("Image address unused");
   a_conv_idle: assert property ((!conv_on && xfer_mode_in == 2'h0) [*2]
      |-> !image_addr_use_out && !dma_addr_use_out) else $error("Idle use");
   a_addr_hold: assert property (host_wr_n_in [*8] |->
      $stable(dma_dest_addr_out) && $stable(image_dest_addr_out))
      else $error("Address stepped");
   a_count_hold: assert property (host_wr_n_in [*8] |->
      $stable(dma_word_count_out)) else $error("Count stepped");
   c_read: cover property ($rose(host_data_oe_out));
   c_offset: cover property (pix_valid_in && ofs_on);
   c_conv: cover property (xfer_mode_in == 2'h3 && image_addr_use_out);
   c_yuv: cover property (conv_on && image_addr_use_out);
endmodule
bind rtcr_top rtcr_props i_rtcr_props (.*);

/* test/rtcr_host.sv */
// Host processor model driving the bank's level strobes
`timescale 1ns/10ps
module rtcr_host (
   input wire sys_clk_in, // System clock
   input wire [15:0] rd_data_in, // Bank read data
   input wire rd_oe_in, // Bank drives the bus
   output reg cs_n_out, // Chip select, active low
   output reg rd_n_out, // Read strobe, active low
   output reg wr_n_out, // Write strobe, active low
   output reg [10:1] addr_out, // Word address
   output reg [15:0] data_out, // Write data
   output reg got_out, // Read data taken this cycle
   output reg [15:0] got_data_out, // Read data taken
   output reg tmo_out // Read answer never came
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
      addr_out = 10'h000;
      data_out = 16'h5A5A;
      got_out = 1'b0;
      got_data_out = 16'h0000;
      tmo_out = 1'b0;
   end
   // Strobe held six edges: the pins pass a three-flop filter
   task host_wr(input [10:0] a, input [15:0] d);
      begin
         @(posedge sys_clk_in);
         cs_n_out <= 1'b0;
         wr_n_out <= 1'b0;
         addr_out <= a[10:1];
         data_out <= d;
         repeat (6) @(posedge sys_clk_in);
         cs_n_out <= 1'b1;
         wr_n_out <= 1'b1;
         data_out <= ~d; // Released bus must not look like old data
         repeat (5) @(posedge sys_clk_in);
      end
   endtask
   task host_rd(input [10:0] a);
      integer i;
      begin
         @(posedge sys_clk_in);
         cs_n_out <= 1'b0;
         rd_n_out <= 1'b0;
         addr_out <= a[10:1];
         @(posedge sys_clk_in);
         for (i = 0; i < 20 && rd_oe_in !== 1'b1; i = i + 1)
            @(posedge sys_clk_in);
         if (i == 20)
            tmo_out <= 1'b1;
         got_out <= 1'b1;
         got_data_out <= rd_data_in;
         @(posedge sys_clk_in);
         got_out <= 1'b0;
         cs_n_out <= 1'b1;
         rd_n_out <= 1'b1;
         repeat (5) @(posedge sys_clk_in);
      end
   endtask
endmodule

/* test/rtcr_top_tb.sv */
// Self-checking bench for the transfer control register bank
`timescale 1ns/10ps
`include "rtcr_regs.vh"
`define CHK(g, e) begin samples_checked = samples_checked + 1; \
   if ((g) !== (e)) begin err_total = err_total + 1; \
   $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module rtcr_top_tb;
   // ****************************************
   // Bench
   // ****************************************
   reg sys_clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [1:0] xfer_mode_in = 2'h0;
   reg [2:0] conv_mode_in = 3'h0;
   reg uclip_load_in = 1'b0;
   reg sclip_load_in = 1'b0;
   reg ret_load_in = 1'b0;
   reg [13:0] uclip_max_y_in = 14'h0000;
   reg [13:0] sclip_max_x_in = 14'h0000;
   reg [13:0] sclip_max_y_in = 14'h0000;
   reg [21:0] ret_addr_in = 22'h000000;
   reg pix_valid_in = 1'b0;
   reg [15:0] pix_in = 16'h0000;
   reg bpp16_in = 1'b0;
   reg quad_cmd_in = 1'b0;
   reg colour_offset_attribute_in = 1'b0;
   wire cs_n, rd_n, wr_n, oe, got, tmo, pix_valid_out;
   wire dma_addr_use_out, image_addr_use_out;
   wire [10:1] addr;
   wire [15:0] wdata, rdata, got_data, pix_out;
   wire [21:0] dma_dest_addr_out, image_dest_addr_out, ret_addr_out;
   wire [18:0] dma_word_count_out;
   integer err_total = 0;
   integer samples_checked = 0;
   integer k, q;
   reg [15:0] rq[$];
   reg [15:0] pq[$];
   reg [15:0] ofs, e;
   reg [15:0] v[0:5];
   reg [26:0] m;
   always #12.5 sys_clk_in = ~sys_clk_in;
   rtcr_top i_rtcr_top (.sys_clk_in, .rst_in,
      .host_cs_n_in(cs_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n),
      .host_addr_in(addr), .host_data_in(wdata), .host_data_out(rdata),
      .host_data_oe_out(oe), .xfer_mode_in, .conv_mode_in, .uclip_load_in,
      .uclip_max_y_in, .sclip_load_in, .sclip_max_x_in, .sclip_max_y_in,
      .ret_load_in, .ret_addr_in, .pix_valid_in, .pix_in, .bpp16_in,
      .quad_cmd_in, .colour_offset_attribute_in, .pix_valid_out, .pix_out,
      .dma_dest_addr_out, .dma_word_count_out, .dma_addr_use_out,
      .image_dest_addr_out, .image_addr_use_out, .ret_addr_out);
   rtcr_host i_rtcr_host (.sys_clk_in(sys_clk_in), .rd_data_in(rdata),
      .rd_oe_in(oe), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .addr_out(addr), .data_out(wdata), .got_out(got),
      .got_data_out(got_data), .tmo_out(tmo));
   function [5:0] sat(input [5:0] c, input [5:0] o, input integer w);
      integer s;
      begin
         s = c + o - (o[w-1] ? (1 << w) : 0);
         if (s < 0)
            s = 0;
         if (s > (1 << w) - 1)
            s = (1 << w) - 1;
         sat = s[5:0];
      end
   endfunction
   function [15:0] exp_pix(input [15:0] p);
      reg [5:0] r, g, b;
      begin
         r = sat(p[15:11], ofs[15:11], 5);
         g = sat(p[10:5], ofs[10:5], 6);
         b = sat(p[4:0], ofs[4:0], 5);
         if (bpp16_in && quad_cmd_in && colour_offset_attribute_in)
            exp_pix = {r[4:0], g, b[4:0]};
         else
            exp_pix = p;
      end
   endfunction
   // Offset and writable bits of each transfer register
   function [26:0] xreg(input integer i);
      case (i)
         0: xreg = {`RTCR_OFF_DMA_ADDR_HI, 16'h007F};
         1: xreg = {`RTCR_OFF_DMA_ADDR_LO, 16'hFFFE};
         2: xreg = {`RTCR_OFF_IMG_ADDR_HI, 16'h007F};
         3: xreg = {`RTCR_OFF_IMG_ADDR_LO, 16'hFFFE};
         4: xreg = {`RTCR_OFF_DMA_CNT_HI, 16'h0007};
         default: xreg = {`RTCR_OFF_DMA_CNT_LO, 16'hFFFF};
      endcase
   endfunction
   task rd_exp(input [10:0] a, input [15:0] x);
      begin
         rq.push_back(x);
         i_rtcr_host.host_rd(a);
      end
   endtask
   task wr_xfer;
      for (k = 0; k < 6; k = k + 1) begin
         m = xreg(k);
         v[k] = 16'($urandom) & m[15:0];
         i_rtcr_host.host_wr(m[26:16], v[k]);
      end
   endtask
   task rd_xfer(input zero);
      for (k = 0; k < 6; k = k + 1) begin
         m = xreg(k);
         rd_exp(m[26:16], zero ? 16'h0000 : v[k]);
      end
   endtask
   task rd_kept;
      begin
         rd_exp(`RTCR_OFF_UCLIP_MAX_Y, {2'b00, uclip_max_y_in});
         rd_exp(`RTCR_OFF_SCLIP_MAX_X, {2'b00, sclip_max_x_in});
         rd_exp(`RTCR_OFF_SCLIP_MAX_Y, {2'b00, sclip_max_y_in});
         rd_exp(`RTCR_OFF_RET_ADDR_HI, {9'h000, ret_addr_in[21:15]});
         rd_exp(`RTCR_OFF_RET_ADDR_LO, {ret_addr_in[14:0], 1'b0});
         rd_exp(`RTCR_OFF_COLOUR_OFS, ofs);
      end
   endtask
   task px(input [15:0] p);
      begin
         @(posedge sys_clk_in);
         pq.push_back(exp_pix(p));
         pix_valid_in <= 1'b1;
         pix_in <= p;
      end
   endtask
   task tally_and_finish;
      begin
         if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   always @(posedge sys_clk_in) begin
      if (got === 1'b1) begin
         e = rq.size() ? rq.pop_front() : 16'hXXXX;
         `CHK(got_data, e)
      end
      if (pix_valid_out === 1'b1) begin
         e = pq.size() ? pq.pop_front() : 16'hXXXX;
         `CHK(pix_out, e)
      end
      if (tmo === 1'b1) begin
         err_total = err_total + 1;
         tally_and_finish;
      end
   end
   initial begin
      void'($urandom(32'h41b3));
      repeat (5) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd_xfer(1'b1);
      wr_xfer;
      rd_xfer(1'b0);
      `CHK(dma_dest_addr_out, {v[0][6:0], v[1][15:1]})
      `CHK(image_dest_addr_out, {v[2][6:0], v[3][15:1]})
      `CHK(dma_word_count_out, {v[4][2:0], v[5]})
      @(posedge sys_clk_in);
      {uclip_load_in, sclip_load_in, ret_load_in} <= 3'h7;
      uclip_max_y_in <= 14'($urandom);
      sclip_max_x_in <= 14'($urandom);
      sclip_max_y_in <= 14'($urandom);
      ret_addr_in <= 22'($urandom);
      @(posedge sys_clk_in);
      {uclip_load_in, sclip_load_in, ret_load_in} <= 3'h0;
      ofs = 16'($urandom);
      i_rtcr_host.host_wr(`RTCR_OFF_COLOUR_OFS, ofs);
      `CHK(ret_addr_out, ret_addr_in)
      i_rtcr_host.host_wr(`RTCR_OFF_UCLIP_MAX_Y, 16'h1555);
      i_rtcr_host.host_wr(`RTCR_OFF_SCLIP_MAX_X, 16'h2AAA);
      i_rtcr_host.host_wr(`RTCR_OFF_SCLIP_MAX_Y, 16'h1555);
      i_rtcr_host.host_wr(`RTCR_OFF_RET_ADDR_LO, 16'hAAAA);
      i_rtcr_host.host_wr(11'h0A0, 16'hFFFF);
      rd_exp(11'h0A0, 16'h0000);
      rd_kept;
      ret_addr_in[21:15] <= 7'h5A;
      i_rtcr_host.host_wr(`RTCR_OFF_RET_ADDR_HI, 16'h005A);
      `CHK(ret_addr_out, ret_addr_in)
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      `CHK(dma_dest_addr_out, 22'h000000)
      rd_xfer(1'b1);
      rd_kept;
      for (q = 0; q < 6; q = q + 1) begin
         ofs = (q == 0) ? 16'h7BEF : (q == 1) ? 16'h8410 : 16'($urandom);
         i_rtcr_host.host_wr(`RTCR_OFF_COLOUR_OFS, ofs);
         {bpp16_in, quad_cmd_in, colour_offset_attribute_in} <=
            (q < 3) ? 3'h7 : (q == 3) ? 3'h2 : (q == 4) ? 3'h5 : 3'h6;
         px(16'hFFFF);
         px(16'h0000);
         for (k = 0; k < 6; k = k + 1)
            px(16'($urandom));
         @(posedge sys_clk_in);
         pix_valid_in <= 1'b0;
      end
      wr_xfer;
      // Host leaves address and count alone while a mode is set
      for (q = 0; q < 4; q = q + 1) begin
         @(posedge sys_clk_in);
         xfer_mode_in <= q[1:0];
         repeat (4) @(posedge sys_clk_in);
         `CHK(dma_addr_use_out, q == 1)
         `CHK(image_addr_use_out, q == 3)
         `CHK(dma_dest_addr_out, {v[0][6:0], v[1][15:1]})
         `CHK(dma_word_count_out, {v[4][2:0], v[5]})
      end
      xfer_mode_in <= 2'h0;
      for (q = 0; q < 8; q = q + 1) begin
         @(posedge sys_clk_in);
         conv_mode_in <= q[2:0];
         repeat (4) @(posedge sys_clk_in);
         `CHK(image_addr_use_out, q < 4 && q > 0 || q == 7)
         `CHK(image_dest_addr_out, {v[2][6:0], v[3][15:1]})
      end
      repeat (10) @(posedge sys_clk_in);
      if (rq.size() || pq.size())
         err_total = err_total + 1;
      tally_and_finish;
   end
endmodule
